// *** logic/dicu_capture.sv ***
`timescale 1ns/1ps
// Summary of operation
// [R1] each channel detects rising, falling or both edges on one of sixteen pins
// [R2] a shared 16-bit counter supplies the time stamp for captures
// [R3] counter advances on the prescale tick, full rate down to 1/256
// [R4] gate mode: start condition begins counting, stop condition halts it
// [R5] counter may also run freely or run until a stop condition
// [R6] start or stop condition can latch the counter value instead
// [R7] start and stop may use one pin with different edge polarity
// [R8] start and stop may come from two different pins
// [R9] pulse mode: first edge clears and starts, second edge captures
// [R10] capture on start, stop or both; interrupt per capture when enabled
// [R11] software can clear and start the counter; inputs then capture
// [R12] counter can be cleared by the match timer output load tick
// [R13] pins pass a synchroniser; each edge gives one one-cycle event
module dicu_capture (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [dicu_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [dicu_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // event pins and timer sync
  input wire logic [dicu_pkg::NUM_PINS-1:0] cap_pins,
  input wire logic sync_load_tick,
  // interrupt
  output logic irq
);
  import dicu_pkg::*;

  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
    logic [15:0] cnt;
    logic running;
    dicu_mode_t mode;
    logic sync_en;
    logic [7:0] presc;
    logic [1:0][13:0] cfg;
    logic [1:0][15:0] cap;
    logic [1:0] stat;
    logic [1:0] mask;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic irq;
  } dicu_state_t;

  dicu_state_t r_reg;
  dicu_state_t r_next;
  logic tick;
  logic [1:0] st_ev;
  logic [1:0] sp_ev;
  logic do_wr;
  logic sw_clr;
  logic sw_start;
  logic [1:0] cap_set;
  logic [1:0] st_run;
  logic [1:0] sp_run;

  // edge test on a chosen synchronised pin
  function automatic logic edge_hit(input logic [15:0] cur, input logic [15:0] prev,
                                    input logic [3:0] pin, input logic [1:0] sel);
    logic rise;
    logic fall;
    rise = cur[pin] & ~prev[pin];
    fall = ~cur[pin] & prev[pin];
    case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // address decode shared by read and write
  function automatic logic addr_known(input logic [7:0] a);
    case (a)
      ADDR_CTRL, ADDR_PRESC, ADDR_CFG0, ADDR_CFG1, ADDR_CAP0, ADDR_CAP1,
      ADDR_STAT, ADDR_MASK, ADDR_COUNT: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    wmerge = (old & ~m) | (d & m);
  endfunction

  // per-channel start and stop events from their own pins and edges
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      assign st_ev[c] = edge_hit(r_reg.s2, r_reg.s3,
        r_reg.cfg[c][CFG_STPIN_LSB +: 4], r_reg.cfg[c][CFG_STEDGE_LSB +: 2]); // [R1] [R7] [R13]
      assign sp_ev[c] = edge_hit(r_reg.s2, r_reg.s3,
        r_reg.cfg[c][CFG_SPPIN_LSB +: 4], r_reg.cfg[c][CFG_SPEDGE_LSB +: 2]); // [R8]
      assign cap_set[c] = (st_ev[c] & r_reg.cfg[c][CFG_CAPST_BIT])
                        | (sp_ev[c] & r_reg.cfg[c][CFG_CAPSP_BIT]); // [R10]
      // a condition chosen for capture latches only, it leaves run control alone
      assign st_run[c] = st_ev[c] & ~r_reg.cfg[c][CFG_CAPST_BIT]; // [R6]
      assign sp_run[c] = sp_ev[c] & ~r_reg.cfg[c][CFG_CAPSP_BIT]; // [R6]
    end
  endgenerate

  // write strobes that act as commands
  assign do_wr = r_reg.aw_held && r_reg.w_held && !r_reg.bvalid;
  assign sw_clr = do_wr && (r_reg.awaddr == ADDR_CTRL) && r_reg.wstrb[0]
                  && r_reg.wdata[CTRL_SWCLR_BIT];
  assign sw_start = do_wr && (r_reg.awaddr == ADDR_CTRL) && r_reg.wstrb[0]
                    && r_reg.wdata[CTRL_SWSTART_BIT];

  // count rate divider
  dicu_prescale u_prescale (
    .aclk(aclk),
    .aresetn(aresetn),
    .div(r_reg.presc),
    .tick(tick)
  );

  // next-state logic
  always_comb begin
    logic [31:0] cur;
    logic [31:0] nw;
    logic [1:0] w1c;
    logic start_any;
    logic stop_any;
    cur = 32'h0000_0000;
    nw = 32'h0000_0000;
    w1c = 2'h0;
    start_any = |st_run;
    stop_any = |sp_run;
    r_next = r_reg;
    // three-stage pin synchroniser
    r_next.s1 = cap_pins; // [R13]
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    // write address and data taken in either order
    if (r_reg.awready && awvalid) begin
      r_next.awaddr = awaddr;
      r_next.aw_held = 1'b1;
    end
    if (r_reg.wready && wvalid) begin
      r_next.wdata = wdata;
      r_next.wstrb = wstrb;
      r_next.w_held = 1'b1;
    end
    if (r_reg.bvalid && bready) begin
      r_next.bvalid = 1'b0;
    end
    // register write
    if (do_wr) begin
      r_next.aw_held = 1'b0;
      r_next.w_held = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = addr_known(r_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (r_reg.awaddr)
        ADDR_CTRL: begin
          cur = {27'h0, r_reg.sync_en, 2'h0, r_reg.mode};
          nw = wmerge(cur, r_reg.wdata, r_reg.wstrb);
          r_next.mode = dicu_mode_t'(nw[CTRL_MODE_LSB +: 2]); // [R5]
          r_next.sync_en = nw[CTRL_SYNC_BIT];
        end
        ADDR_PRESC: begin
          nw = wmerge({24'h0, r_reg.presc}, r_reg.wdata, r_reg.wstrb);
          r_next.presc = nw[7:0]; // [R3]
        end
        ADDR_CFG0: begin
          nw = wmerge({18'h0, r_reg.cfg[0]}, r_reg.wdata, r_reg.wstrb);
          r_next.cfg[0] = nw[CFG_W-1:0];
        end
        ADDR_CFG1: begin
          nw = wmerge({18'h0, r_reg.cfg[1]}, r_reg.wdata, r_reg.wstrb);
          r_next.cfg[1] = nw[CFG_W-1:0];
        end
        ADDR_STAT: begin
          if (r_reg.wstrb[0]) begin
            w1c = r_reg.wdata[1:0];
          end
        end
        ADDR_MASK: begin
          nw = wmerge({30'h0, r_reg.mask}, r_reg.wdata, r_reg.wstrb);
          r_next.mask = nw[1:0];
        end
        default: begin
          nw = 32'h0000_0000;
        end
      endcase
    end
    r_next.awready = !r_next.aw_held && !r_next.bvalid;
    r_next.wready = !r_next.w_held && !r_next.bvalid;
    // register read
    if (r_reg.rvalid && rready) begin
      r_next.rvalid = 1'b0;
    end
    if (r_reg.arready && arvalid) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = addr_known(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        ADDR_CTRL: r_next.rdata = {27'h0, r_reg.sync_en, 2'h0, r_reg.mode};
        ADDR_PRESC: r_next.rdata = {24'h0, r_reg.presc};
        ADDR_CFG0: r_next.rdata = {18'h0, r_reg.cfg[0]};
        ADDR_CFG1: r_next.rdata = {18'h0, r_reg.cfg[1]};
        ADDR_CAP0: r_next.rdata = {16'h0, r_reg.cap[0]};
        ADDR_CAP1: r_next.rdata = {16'h0, r_reg.cap[1]};
        ADDR_STAT: r_next.rdata = {30'h0, r_reg.stat};
        ADDR_MASK: r_next.rdata = {30'h0, r_reg.mask};
        ADDR_COUNT: r_next.rdata = {15'h0, r_reg.running, r_reg.cnt};
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
    r_next.arready = !r_next.rvalid;
    // run control per mode
    case (r_reg.mode)
      MODE_GATE: begin
        if (start_any) begin
          r_next.running = 1'b1; // [R4]
        end else if (stop_any) begin
          r_next.running = 1'b0; // [R4]
        end
      end
      MODE_FREE: r_next.running = 1'b1; // [R5]
      MODE_UNTIL: begin
        if (stop_any) begin
          r_next.running = 1'b0; // [R5]
        end
      end
      MODE_PULSE: begin
        if (start_any) begin
          r_next.running = 1'b1; // [R9]
        end else if (stop_any) begin
          r_next.running = 1'b0;
        end
      end
      default: r_next.running = r_reg.running;
    endcase
    if (sw_start) begin
      r_next.running = 1'b1; // [R11]
    end
    // counter: clear, restart or advance
    if (sw_clr || (r_reg.sync_en && sync_load_tick)) begin
      r_next.cnt = 16'h0000; // [R11] [R12]
    end else if (r_reg.mode == MODE_PULSE && start_any) begin
      r_next.cnt = 16'h0000; // [R9]
    end else if (r_reg.running && tick) begin
      r_next.cnt = r_reg.cnt + 16'h0001; // [R2] [R3]
    end
    // captures latch the count, set wins over clear
    for (int c = 0; c < NUM_CH; c++) begin
      if (cap_set[c]) begin
        r_next.cap[c] = r_reg.cnt; // [R6]
      end
    end
    r_next.stat = (r_reg.stat & ~w1c) | cap_set; // [R10]
    r_next.irq = |(r_next.stat & r_next.mask); // [R10]
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops
  assign awready = r_reg.awready;
  assign wready = r_reg.wready;
  assign bvalid = r_reg.bvalid;
  assign bresp = r_reg.bresp;
  assign arready = r_reg.arready;
  assign rvalid = r_reg.rvalid;
  assign rresp = r_reg.rresp;
  assign rdata = r_reg.rdata;
  assign irq = r_reg.irq;

  // checks
  localparam int BRSP_MIN = 1;
  localparam int BRSP_MAX = 2;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_go;
    r_reg.aw_held && r_reg.w_held && !r_reg.bvalid;
  endsequence
  sequence s_pulse_start;
    (r_reg.mode == MODE_PULSE) && (|st_run) && !sw_clr && !(r_reg.sync_en && sync_load_tick);
  endsequence

  property p_single_event;
    st_ev[0] && $stable(r_reg.s1) && !do_wr |=> !st_ev[0];
  endproperty
  a_single_event: assert property (p_single_event) else $error("event longer than one cycle"); // [R13]
  property p_pin_to_event;
    (r_reg.cfg[0][CFG_STEDGE_LSB +: 2] == EDGE_RISE) && $rose(r_reg.s1[r_reg.cfg[0][3:0]])
      && $stable(r_reg.cfg[0]) && !do_wr |=> st_ev[0];
  endproperty
  a_pin_to_event: assert property (p_pin_to_event) else $error("rising edge missed"); // [R1]
  property p_advance;
    r_reg.running && tick && !sw_clr && !(r_reg.sync_en && sync_load_tick) && !(|st_ev)
      |=> r_reg.cnt == $past(r_reg.cnt) + 16'h0001;
  endproperty
  a_advance: assert property (p_advance) else $error("counter did not advance"); // [R3]
  property p_hold;
    !tick && !sw_clr && !sync_load_tick && !(|st_ev) |=> $stable(r_reg.cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without tick"); // [R2]
  property p_gate;
    (r_reg.mode == MODE_GATE) && !sw_start && (|sp_run) && !(|st_run) |=> !r_reg.running;
  endproperty
  a_gate: assert property (p_gate) else $error("stop did not halt counter"); // [R4]
  property p_free;
    (r_reg.mode == MODE_FREE) |=> r_reg.running;
  endproperty
  a_free: assert property (p_free) else $error("free mode not running"); // [R5]
  property p_capture;
    cap_set[1] |=> r_reg.cap[1] == $past(r_reg.cnt) && r_reg.stat[1];
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong"); // [R6]
  property p_irq;
    (|(cap_set & r_reg.mask)) && !do_wr |=> irq ##1 (irq || !(|r_reg.stat));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised"); // [R10]
  property p_pulse;
    s_pulse_start |=> (r_reg.cnt == 16'h0000) && r_reg.running;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse start did not restart"); // [R9]
  property p_swclr;
    sw_clr |=> r_reg.cnt == 16'h0000;
  endproperty
  a_swclr: assert property (p_swclr) else $error("software clear failed"); // [R11]
  property p_sync;
    r_reg.sync_en && sync_load_tick |=> r_reg.cnt == 16'h0000;
  endproperty
  a_sync: assert property (p_sync) else $error("timer sync clear failed"); // [R12]
  property p_wr_resp;
    s_wr_go |-> ##[BRSP_MIN:BRSP_MAX] bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
endmodule // dicu_capture

// *** logic/dicu_pkg.sv ***
package dicu_pkg;
  // sizes
  localparam int NUM_CH = 2;
  localparam int NUM_PINS = 16;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PRESC = 8'h04;
  localparam logic [7:0] ADDR_CFG0 = 8'h08;
  localparam logic [7:0] ADDR_CFG1 = 8'h0C;
  localparam logic [7:0] ADDR_CAP0 = 8'h10;
  localparam logic [7:0] ADDR_CAP1 = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1C;
  localparam logic [7:0] ADDR_COUNT = 8'h20;

  // control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SWCLR_BIT = 2;
  localparam int CTRL_SWSTART_BIT = 3;
  localparam int CTRL_SYNC_BIT = 4;

  // channel config fields, then the run bit of the count register
  localparam int CFG_W = 14;
  localparam int CFG_STPIN_LSB = 0;
  localparam int CFG_SPPIN_LSB = 4;
  localparam int CFG_STEDGE_LSB = 8;
  localparam int CFG_SPEDGE_LSB = 10;
  localparam int CFG_CAPST_BIT = 12;
  localparam int CFG_CAPSP_BIT = 13;
  localparam int COUNT_RUN_BIT = 16;

  // reset values
  localparam logic [7:0] RST_PRESC = 8'h00;
  localparam logic [13:0] RST_CFG = 14'h0000;
  localparam logic [1:0] RST_MASK = 2'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // counter run modes
  typedef enum logic [1:0] {
    MODE_GATE = 2'b00,
    MODE_FREE = 2'b01,
    MODE_UNTIL = 2'b10,
    MODE_PULSE = 2'b11
  } dicu_mode_t;

  // edge selection
  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } dicu_edge_t;
endpackage

// *** logic/dicu_prescale.sv ***
`timescale 1ns/1ps
module dicu_prescale (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // divide setting, tick out
  input wire logic [7:0] div,
  output logic tick
);
  import dicu_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } dicu_psc_t;

  dicu_psc_t r_reg;
  dicu_psc_t r_next;

  // count down, tick once per div+1 clocks
  always_comb begin
    r_next = r_reg;
    r_next.tick = 1'b0;
    if (r_reg.cnt == 8'h00) begin
      r_next.tick = 1'b1; // [R3]
      r_next.cnt = div;
    end else begin
      r_next.cnt = r_reg.cnt - 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;
endmodule // dicu_prescale

// *** dv/dicu_pin_src.sv ***
`timescale 1ns/1ps
// outside event source for the capture pins
module dicu_pin_src (
  // clock
  input wire logic aclk,
  // wanted levels in, pin levels out
  input wire logic [15:0] level_cmd,
  output logic [15:0] pins
);
  // idle low until the bench asks otherwise
  initial begin
    pins = 16'h0000;
  end
  // pins follow the wanted levels one edge later
  always @(posedge aclk) begin
    pins <= level_cmd;
  end
endmodule // dicu_pin_src

// *** dv/dual_input_capture_unit_bench.sv ***
`timescale 1ns/1ps
module dual_input_capture_unit_bench;
  import dicu_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sync_load_tick, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] pin_cmd, cap_pins;
  int fail_count, n_compared;

  // design and pin source
  dicu_capture uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cap_pins(cap_pins), .sync_load_tick(sync_load_tick), .irq(irq));
  dicu_pin_src pin_src (.aclk(aclk), .level_cmd(pin_cmd), .pins(cap_pins));

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check_eq(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_rng(input string what, input logic [31:0] lo, input logic [31:0] hi,
                           input logic [31:0] got);
    n_compared++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      fail_count++;
      $display("unexpected %s: expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask

  task automatic timed_out();
    fail_count++;
    $display("unexpected bus answer: expected response seen none");
    report_and_stop();
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) timed_out();
    bready <= 1'b0;
    check_eq("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  // read: result left in rd
  task automatic rdr(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) timed_out();
    rd = rdata;
    rready <= 1'b0;
    check_eq("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic set_pin(input int i, input logic v);
    @(posedge aclk);
    pin_cmd[i] <= v;
    wait_clk(6);
  endtask

  task automatic t_reset_values();
    for (int a = 0; a <= 32; a += 4) begin
      rdr(8'(a));
      check_eq("reset value", 32'h0, rd);
    end
    rdr(8'h24, RESP_SLVERR);
    check_eq("unmapped data", 32'h0, rd);
    wr(8'h24, 32'h1, RESP_SLVERR);
  endtask

  task automatic t_free_prescale();
    logic [31:0] c0;
    wr(ADDR_PRESC, 32'h3);
    wr(ADDR_CTRL, 32'h1);
    rdr(ADDR_COUNT);
    c0 = rd;
    wait_clk(400);
    rdr(ADDR_COUNT);
    check_eq("running", 32'h1, {31'h0, rd[16]});
    check_rng("count step", 32'd99, 32'd101, {16'h0, rd[15:0] - c0[15:0]});
    wr(ADDR_PRESC, 32'h0);
  endtask

  task automatic t_gate();
    logic [31:0] c0;
    wr(ADDR_CFG0, 32'h933);
    wr(ADDR_CTRL, 32'h0); // gate mode, so the pulse below stops the counter
    set_pin(3, 1'b1);
    set_pin(3, 1'b0);
    wr(ADDR_CTRL, 32'h4);
    rdr(ADDR_COUNT);
    check_eq("stopped count", 32'h0, rd);
    set_pin(3, 1'b1);
    wait_clk(44);
    set_pin(3, 1'b0);
    rdr(ADDR_COUNT);
    c0 = rd;
    check_rng("gated count", 32'd49, 32'd53, c0);
    wait_clk(20);
    rdr(ADDR_COUNT);
    check_eq("held count", c0, rd);
  endtask

  task automatic t_swclear();
    wr(ADDR_CFG0, 32'h1103);
    wr(ADDR_CTRL, 32'hC);
    rdr(ADDR_CTRL);
    check_eq("ctrl readback", 32'h0, rd);
    wait_clk(20);
    set_pin(3, 1'b1);
    rdr(ADDR_CAP0);
    check_rng("sw start capture", 32'd22, 32'd32, rd);
    set_pin(3, 1'b0);
    wr(ADDR_STAT, 32'h3);
  endtask

  task automatic t_pulse_irq();
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_CFG1, 32'h2595);
    wr(ADDR_MASK, 32'h2);
    set_pin(5, 1'b1);
    wait_clk(23);
    set_pin(9, 1'b1);
    rdr(ADDR_CAP1);
    check_rng("pulse width", 32'd28, 32'd32, rd);
    rdr(ADDR_STAT);
    check_eq("capture flag", 32'h2, rd);
    check_eq("irq", 32'h1, {31'h0, irq});
    wr(ADDR_STAT, 32'h2);
    wait_clk(2);
    check_eq("irq cleared", 32'h0, {31'h0, irq});
    wr(ADDR_MASK, 32'h0);
    set_pin(5, 1'b0);
    set_pin(9, 1'b0);
    set_pin(5, 1'b1);
    set_pin(9, 1'b1);
    rdr(ADDR_STAT);
    check_eq("masked flag", 32'h2, rd);
    check_eq("masked irq", 32'h0, {31'h0, irq});
    wr(ADDR_STAT, 32'h3);
  endtask

  task automatic t_edges();
    wr(ADDR_CTRL, 32'h8); // gate mode, software start
    for (int e = 0; e < 4; e++) begin
      wr(ADDR_CFG0, 32'h2070 | (32'(e) << 10)); // stop edge e on pin 7, capture on stop
      set_pin(7, 1'b1);
      rdr(ADDR_STAT);
      check_eq("rise flag", {31'h0, e[0]}, rd);
      wr(ADDR_STAT, 32'h3);
      set_pin(7, 1'b0);
      rdr(ADDR_STAT);
      check_eq("fall flag", {31'h0, e[1]}, rd);
      wr(ADDR_STAT, 32'h3);
    end
    rdr(ADDR_COUNT);
    check_eq("still running", 32'h1, {31'h0, rd[16]});
  endtask

  task automatic t_sync();
    wr(ADDR_CTRL, 32'h11);
    wait_clk(100);
    sync_load_tick <= 1'b1;
    @(posedge aclk);
    sync_load_tick <= 1'b0;
    rdr(ADDR_COUNT);
    check_rng("count after sync", 32'h10000, 32'h10008, rd);
  endtask

  // reset, then the scenarios in turn
  initial begin
    fail_count = 0;
    n_compared = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, sync_load_tick} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    pin_cmd = 16'h0000;
    wait_clk(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values();
    t_free_prescale();
    t_gate();
    t_swclear();
    t_pulse_irq();
    t_edges();
    t_sync();
    report_and_stop();
  end
endmodule // dual_input_capture_unit_bench
